// ---- logic/rtid_defines.svh ----
// Register indices, field positions and reset values of the remote target id table.
// Assumes an APB slave with 32-bit data and one word per register index.
`ifndef RTID_DEFINES_SVH
`define RTID_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define RTID_IDX_PHYS0 8'h08
`define RTID_IDX_PHYS1 8'h09
`define RTID_IDX_PHYS2 8'h0a
`define RTID_IDX_PHYS3 8'h0b
`define RTID_IDX_PHYS4 8'h0c
`define RTID_IDX_PHYS5 8'h0d
`define RTID_IDX_PHYS6 8'h0e
`define RTID_IDX_PHYS7 8'h0f
`define RTID_IDX_ALIAS0 8'h10
`define RTID_IDX_ALIAS1 8'h11
`define RTID_IDX_ALIAS2 8'h12
`define RTID_IDX_ALIAS3 8'h13
`define RTID_IDX_ALIAS4 8'h14
`define RTID_IDX_ALIAS5 8'h15
`define RTID_IDX_ALIAS6 8'h16
`define RTID_IDX_ALIAS7 8'h17

// ==========================================================
// Field layout and reset values
`define RTID_NUM_SLOTS 8
`define RTID_FIELD_MSB 7
`define RTID_FIELD_LSB 1
`define RTID_PHYS_RESET 7'h00
`define RTID_ALIAS_RESET 7'h00
`define RTID_ALIAS_OFF 7'h00
`define RTID_RSVD_BIT 1'b0

`endif

// ---- logic/rtid_pkg.sv ----
// Types shared by the remote target id table and its alias matcher.
// Assumes nothing beyond the defines header.
package rtid_pkg;

	// ==========================================================
	// Address and table types
	typedef logic [6:0] rtid_addr_t;
	typedef logic [2:0] rtid_slot_t;
	typedef logic [7:0][6:0] rtid_tbl_t;

	// ==========================================================
	// Bus answer states
	typedef enum logic [1:0] {
		RTID_ST_IDLE = 2'b01,
		RTID_ST_ANSWER = 2'b10
	} rtid_apb_st_t;

endpackage

// ---- logic/rtid_match.sv ----
// Alias matcher: finds the lowest slot whose alias equals the incoming address.
// Assumes the alias table and address are stable for the cycle in which they are read.
`timescale 1ns/1ps
`include "rtid_defines.svh"

module rtid_match (
	// Alias table
	input wire rtid_pkg::rtid_tbl_t i_alias_tbl,
	// Incoming address
	input wire rtid_pkg::rtid_addr_t i_addr,
	// Result
	output logic o_hit,
	output rtid_pkg::rtid_slot_t o_slot
);

	// ==========================================================
	// Per-slot compare
	logic [`RTID_NUM_SLOTS-1:0] eq;

	genvar g;
	generate
		for (g = 0; g < `RTID_NUM_SLOTS; g++) begin : g_cmp
			// Zero alias never matches
			assign eq[g] = (i_alias_tbl[g] == i_addr) && (i_alias_tbl[g] != `RTID_ALIAS_OFF);
		end
	endgenerate

	// ==========================================================
	// Priority pick, lowest slot wins
	always_comb begin
		o_hit = 1'b0;
		o_slot = 3'h0;
		for (int k = `RTID_NUM_SLOTS - 1; k >= 0; k--) begin
			if (eq[k]) begin
				o_hit = 1'b1;
				o_slot = 3'(k);
			end
		end
	end

endmodule // rtid_match

// ---- logic/rtid_top.sv ----
// Remote target id table: alias and physical address slots with address substitution.
// Assumes an APB master on i_clock and a request source on the same clock.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "rtid_defines.svh"

module rtid_top (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Local transaction address
	input wire logic i_req_valid,
	input wire logic [6:0] i_req_addr,
	input wire logic i_req_rnw,
	// Forward toward control channel
	output logic o_fwd_valid,
	output logic [6:0] o_fwd_addr,
	output logic o_fwd_rnw,
	output logic [2:0] o_fwd_slot,
	output logic o_miss
);

	// ==========================================================
	// Address decode
	// Result: {mapped, is_alias, slot[2:0]}
	function automatic logic [4:0] rtid_decode(input logic [11:0] addr);
		logic [4:0] res;
		res = 5'h00;
		if (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) begin
			case (addr[9:2])
				`RTID_IDX_PHYS0: res = 5'h10;
				`RTID_IDX_PHYS1: res = 5'h11;
				`RTID_IDX_PHYS2: res = 5'h12;
				`RTID_IDX_PHYS3: res = 5'h13;
				`RTID_IDX_PHYS4: res = 5'h14;
				`RTID_IDX_PHYS5: res = 5'h15;
				`RTID_IDX_PHYS6: res = 5'h16;
				`RTID_IDX_PHYS7: res = 5'h17;
				`RTID_IDX_ALIAS0: res = 5'h18;
				`RTID_IDX_ALIAS1: res = 5'h19;
				`RTID_IDX_ALIAS2: res = 5'h1a;
				`RTID_IDX_ALIAS3: res = 5'h1b;
				`RTID_IDX_ALIAS4: res = 5'h1c;
				`RTID_IDX_ALIAS5: res = 5'h1d;
				`RTID_IDX_ALIAS6: res = 5'h1e;
				`RTID_IDX_ALIAS7: res = 5'h1f;
				default: res = 5'h00;
			endcase
		end
		return res;
	endfunction

	// ==========================================================
	// State
	rtid_pkg::rtid_apb_st_t st_reg;
	rtid_pkg::rtid_apb_st_t st_next;
	logic pready_reg;
	logic pready_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	rtid_pkg::rtid_tbl_t phys_reg;
	rtid_pkg::rtid_tbl_t phys_next;
	rtid_pkg::rtid_tbl_t alias_reg;
	rtid_pkg::rtid_tbl_t alias_next;
	logic fwd_valid_reg;
	logic fwd_valid_next;
	rtid_pkg::rtid_addr_t fwd_addr_reg;
	rtid_pkg::rtid_addr_t fwd_addr_next;
	logic fwd_rnw_reg;
	logic fwd_rnw_next;
	rtid_pkg::rtid_slot_t fwd_slot_reg;
	rtid_pkg::rtid_slot_t fwd_slot_next;
	logic miss_reg;
	logic miss_next;

	// ==========================================================
	// Decode and match signals
	logic [4:0] dec;
	logic wr_commit;
	rtid_pkg::rtid_slot_t wr_slot;
	rtid_pkg::rtid_addr_t wr_field;
	logic match_hit;
	rtid_pkg::rtid_slot_t match_slot;
	rtid_pkg::rtid_addr_t alias_sel;
	rtid_pkg::rtid_addr_t phys_sel;

	assign dec = rtid_decode(i_paddr);
	assign wr_slot = dec[2:0];
	assign wr_field = i_pwdata[`RTID_FIELD_MSB:`RTID_FIELD_LSB];
	assign wr_commit = (st_reg == rtid_pkg::RTID_ST_ANSWER) && i_psel && i_penable &&
		i_pwrite && pready_reg && !pslverr_reg && i_pstrb[0];
	assign alias_sel = alias_reg[match_slot];
	assign phys_sel = phys_reg[match_slot];

	rtid_match u_match (
		.i_alias_tbl(alias_reg),
		.i_addr(i_req_addr),
		.o_hit(match_hit),
		.o_slot(match_slot)
	);

	// ==========================================================
	// APB answer
	always_comb begin
		st_next = st_reg;
		pready_next = 1'b0;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		case (st_reg)
			rtid_pkg::RTID_ST_IDLE: begin
				if (i_psel && !i_penable) begin
					st_next = rtid_pkg::RTID_ST_ANSWER;
					pready_next = 1'b1;
					pslverr_next = !dec[4];
					if (!dec[4]) begin
						prdata_next = 32'h0;
					end else if (dec[3]) begin
						prdata_next = {24'h0, alias_reg[dec[2:0]], `RTID_RSVD_BIT};
					end else begin
						prdata_next = {24'h0, phys_reg[dec[2:0]], `RTID_RSVD_BIT};
					end
				end
			end
			rtid_pkg::RTID_ST_ANSWER: begin
				st_next = rtid_pkg::RTID_ST_IDLE;
			end
			default: begin
				st_next = rtid_pkg::RTID_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= rtid_pkg::RTID_ST_IDLE;
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0;
			pslverr_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			pready_reg <= pready_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ==========================================================
	// Slot registers
	always_comb begin
		phys_next = phys_reg;
		alias_next = alias_reg;
		if (wr_commit) begin
			if (dec[3]) begin
				alias_next[wr_slot] = wr_field;
			end else begin
				// Bit 0 is never stored
				phys_next[wr_slot] = wr_field;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phys_reg <= {`RTID_NUM_SLOTS{`RTID_PHYS_RESET}};
			alias_reg <= {`RTID_NUM_SLOTS{`RTID_ALIAS_RESET}};
		end else begin
			phys_reg <= phys_next;
			alias_reg <= alias_next;
		end
	end

	// ==========================================================
	// Address substitution
	always_comb begin
		fwd_valid_next = i_req_valid && match_hit;
		miss_next = i_req_valid && !match_hit;
		fwd_addr_next = fwd_addr_reg;
		fwd_rnw_next = fwd_rnw_reg;
		fwd_slot_next = fwd_slot_reg;
		if (i_req_valid && match_hit) begin
			fwd_addr_next = phys_sel;
			fwd_rnw_next = i_req_rnw;
			fwd_slot_next = match_slot;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fwd_valid_reg <= 1'b0;
			fwd_addr_reg <= 7'h00;
			fwd_rnw_reg <= 1'b0;
			fwd_slot_reg <= 3'h0;
			miss_reg <= 1'b0;
		end else begin
			fwd_valid_reg <= fwd_valid_next;
			fwd_addr_reg <= fwd_addr_next;
			fwd_rnw_reg <= fwd_rnw_next;
			fwd_slot_reg <= fwd_slot_next;
			miss_reg <= miss_next;
		end
	end

	// ==========================================================
	// Outputs
	assign o_pready = pready_reg;
	assign o_prdata = prdata_reg;
	assign o_pslverr = pslverr_reg;
	assign o_fwd_valid = fwd_valid_reg;
	assign o_fwd_addr = fwd_addr_reg;
	assign o_fwd_rnw = fwd_rnw_reg;
	assign o_fwd_slot = fwd_slot_reg;
	assign o_miss = miss_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	logic first_reg;
	logic first_next;
	always_comb begin
		first_next = 1'b0;
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= first_next;
		end
	end

	sequence setup_s;
		i_psel && !i_penable && (st_reg == rtid_pkg::RTID_ST_IDLE);
	endsequence

	sequence answer_s;
		o_pready && i_psel && i_penable;
	endsequence

	sequence hit_req_s;
		i_req_valid && match_hit;
	endsequence

	property phys_write_p;
		wr_commit && !dec[3] |=> phys_reg[$past(wr_slot)] == $past(wr_field);
	endproperty

	property subst_p;
		hit_req_s |=> o_fwd_valid && (o_fwd_addr == $past(phys_sel)) &&
			(o_fwd_slot == $past(match_slot));
	endproperty

	rst_zero_a: assert property (first_reg |-> phys_reg == '0 && alias_reg == '0)
		else $error("Slot registers not zero after reset");

	phys_write_a: assert property (phys_write_p)
		else $error("Physical slot write not stored");

	read_bit0_a: assert property (setup_s ##1 answer_s |-> !o_pslverr |-> o_prdata[0] == 1'b0)
		else $error("Reserved bit reads nonzero");

	addr_subst_a: assert property (subst_p)
		else $error("Forwarded address not the slot physical address");

	slot_pair_a: assert property (o_fwd_valid |-> $past(alias_sel) == $past(i_req_addr))
		else $error("Forwarded slot alias does not match request");

	zero_alias_a: assert property (o_fwd_valid |-> $past(alias_sel) != `RTID_ALIAS_OFF)
		else $error("Zero alias produced a forward");

	miss_flag_a: assert property (i_req_valid && !match_hit |=> o_miss && !o_fwd_valid)
		else $error("Unmatched request not reported as miss");

	alias0_write_a: assert property (wr_commit && dec == 5'h18 |=> alias_reg[0] == $past(wr_field))
		else $error("Alias slot 0 write not stored");

	apb_answer_a: assert property (setup_s |=> answer_s or (o_pready && !i_psel))
		else $error("No answer in access cycle");

	genvar s;
	generate
		for (s = 2; s < `RTID_NUM_SLOTS; s++) begin : g_rdchk
			slot_read_a: assert property (
				(setup_s and (!i_pwrite && i_paddr == {2'h0, 8'(`RTID_IDX_PHYS0 + s), 2'h0}))
				|=> !o_pslverr && o_prdata == {24'h0, phys_reg[s], `RTID_RSVD_BIT})
				else $error("Physical slot read mismatch");
		end
	endgenerate

endmodule // rtid_top

// ---- tb/rtid_far.sv ----
// Local request source: issues address lookups toward the target id table.
// Assumes the bench calls its tasks from one process, once per clock edge.
`timescale 1ns/1ps

module rtid_far (
	// Clock
	input wire logic i_clock,
	// Request toward the table
	output logic o_req_valid,
	output logic [6:0] o_req_addr,
	output logic o_req_rnw
);
	// ==========================================================
	// Idle state and request tasks
	initial begin
		o_req_valid = 1'b0;
		o_req_addr = 7'h00;
		o_req_rnw = 1'b0;
	end

	task automatic send(input logic [6:0] a, input logic r);
		@(posedge i_clock);
		o_req_valid <= 1'b1;
		o_req_addr <= a;
		o_req_rnw <= r;
	endtask

	// Released lines show the inverse of the last value
	task automatic idle();
		@(posedge i_clock);
		o_req_valid <= 1'b0;
		o_req_addr <= ~o_req_addr;
		o_req_rnw <= ~o_req_rnw;
	endtask
endmodule // rtid_far

// ---- tb/rtid_top_tb_top.sv ----
// Self-checking bench of the remote target id table: APB access and lookups.
// Assumes the design answers APB within the watchdog span and lookups one cycle later.
`timescale 1ns/1ps

module rtid_top_tb_top;
	// ==========================================================
	// Signals and models
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rv, rrnw;
	logic fv, frnw, miss;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [6:0] raddr, faddr;
	logic [2:0] fslot;
	logic [6:0] phys [8];
	logic [6:0] alias_v [8];
	logic [33:0] aq [$];
	logic [11:0] lq [$];
	logic [33:0] ea;
	logic [11:0] el;
	int error_cnt, checked, seed;

	always #2 clk = ~clk;

	rtid_top rtid_top_i (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_req_valid(rv),
		.i_req_addr(raddr), .i_req_rnw(rrnw), .o_fwd_valid(fv), .o_fwd_addr(faddr),
		.o_fwd_rnw(frnw), .o_fwd_slot(fslot), .o_miss(miss));
	rtid_far rtid_far_i (.i_clock(clk), .o_req_valid(rv), .o_req_addr(raddr), .o_req_rnw(rrnw));

	// ==========================================================
	// Compare, close and watchdog
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#40000;
		error_cnt++;
		close_out();
	end

	// ==========================================================
	// Drivers
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
		input logic [3:0] st);
		logic ok;
		ok = (idx >= 8'h08) && (idx <= 8'h17);
		if (ok && w && st[0]) begin
			if (idx < 8'h10) phys[idx[2:0]] = d[7:1];
			else alias_v[idx[2:0]] = d[7:1];
		end
		aq.push_back({w, ~ok, ok ? {24'h0, idx < 8'h10 ? phys[idx[2:0]] :
			alias_v[idx[2:0]], 1'b0} : 32'h0});
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		pstrb <= st;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask

	function automatic logic [11:0] pred(input logic [6:0] a, input logic r);
		logic [11:0] res;
		res = 12'h000;
		for (int k = 7; k >= 0; k--)
			if (alias_v[k] != 7'h00 && alias_v[k] == a) res = {1'b1, phys[k], 3'(k), r};
		return res;
	endfunction

	task automatic look(input logic [6:0] a);
		logic r;
		r = 1'($random(seed));
		lq.push_back(pred(a, r));
		rtid_far_i.send(a, r);
	endtask

	// ==========================================================
	// Monitor
	always @(negedge clk) begin
		if (pready === 1'b1) begin
			ea = aq.pop_front();
			chk("pslverr", 32'(pslverr), 32'(ea[32]));
			if (!ea[33]) chk("prdata", prdata, ea[31:0]);
		end
		if (fv === 1'b1 || miss === 1'b1) begin
			el = lq.pop_front();
			if (el[11]) chk("fwd", 32'({fv, miss, faddr, fslot, frnw}), 32'({2'b10, el[10:0]}));
			else chk("miss", 32'({fv, miss}), 32'h1);
		end
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 32'h028d;
		clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		for (int k = 0; k < 8; k++) begin
			phys[k] = 7'h00;
			alias_v[k] = 7'h00;
		end
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 8; i < 24; i++) apb(1'b0, 8'(i), 32'h0, 4'h0);
		for (int i = 8; i < 16; i++) apb(1'b1, 8'(i), $random(seed), 4'hf);
		apb(1'b1, 8'h0a, 32'hff, 4'he);
		apb(1'b1, 8'h18, 32'hfe, 4'hf);
		for (int i = 8; i < 25; i++) apb(1'b0, 8'(i), 32'h0, 4'h0);
		look(7'(1 + $random(seed) % 100));
		look(7'h00);
		rtid_far_i.idle();
		for (int k = 0; k < 8; k++) apb(1'b1, 8'(16 + k), 32'((16 + k) * 2 + 1), 4'hf);
		apb(1'b1, 8'h17, 32'h22, 4'hf);
		for (int k = 0; k < 8; k++) look(7'(16 + k));
		look(7'h00);
		rtid_far_i.idle();
		apb(1'b1, 8'h13, 32'h0, 4'hf);
		look(7'h13);
		look(7'h11);
		rtid_far_i.idle();
		// Mid-run reset: slots written above must come back as zero
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			phys[k] = 7'h00;
			alias_v[k] = 7'h00;
		end
		for (int i = 8; i < 24; i++) apb(1'b0, 8'(i), 32'h0, 4'h0);
		look(7'h11);
		rtid_far_i.idle();
		repeat (5) @(posedge clk);
		chk("queues", 32'(aq.size() + lq.size()), 32'h0);
		close_out();
	end
endmodule // rtid_top_tb_top
